// >>> core/edpn_regs.sv
// per-phy mmd indirect window and energy-detect link pulse control
// ==========================================================
// Summary of operation
// - function 00 address, 01 data, others reserved
// - five-bit device select picks mmd target
// - address mode: data register holds mmd address
// - data mode: access latched address, no increment
// - tx enable sends periodic pulses in power-down
// - pulses need mode enable and power-down state
// - tx interval 1s, 768, 512, 256 ms
// - single-pulse wake or two pulses within spacing
// - rx max spacing 64, 256, 512 ms, 1s
// - independent mode per port, else both down
// - preserved fields survive soft reset
// - mode control bit enables power-down, default 0
`timescale 1ns/10ps
module edpn_regs (
	input  wire logic                 mclk,
	input  wire logic                 rstn,
	input  wire logic                 phy_soft_reset,
	input  wire edpn_pkg::edpn_req_t  req,
	output logic [15:0]               rdata,
	input  wire logic                 phy_in_power_down,
	input  wire logic                 peer_port_power_down,
	input  wire logic                 rx_link_pulse,
	input  wire logic [15:0]          mmd_rdata,
	output edpn_pkg::edpn_mmd_t       mmd,
	output logic                      energy_detect_powerdown_enable,
	output logic                      tx_link_pulse,
	output logic                      wake
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [15:0]         ctrl;
		logic [15:0]         addat;
		logic [15:0]         cfg;
		logic [15:0]         mode;
		logic [15:0]         rdata;
		edpn_pkg::edpn_mmd_t mmd;
		logic [2:0]          sync_pd;
		logic [2:0]          sync_peer;
		logic [2:0]          sync_rx;
		logic                pulse_seen;
		logic                tx_pulse;
		logic                wake;
	} edpn_st_t;

	edpn_st_t    st_reg;
	edpn_st_t    st_next;
	logic        ms_tick;
	logic        tx_start;
	logic        tx_expire;
	logic        tx_running;
	logic        rx_start;
	logic        rx_stop;
	logic        rx_running;
	logic        rx_expire;
	logic        tx_allowed;
	logic        rx_edge;
	logic [10:0] tx_limit;
	logic [10:0] rx_limit;
	edpn_pkg::edpn_func_t func;

	edpn_ms_tick u_tick (
		.mclk (mclk),
		.rstn (rstn),
		.tick (ms_tick)
	);

	edpn_ms_timer u_tx_tmr (
		.mclk     (mclk),
		.rstn     (rstn),
		.ms_tick  (ms_tick),
		.start    (tx_start),
		.stop     (!tx_allowed),
		.limit_ms (tx_limit),
		.running  (tx_running),
		.expire   (tx_expire)
	);

	edpn_ms_timer u_rx_tmr (
		.mclk     (mclk),
		.rstn     (rstn),
		.ms_tick  (ms_tick),
		.start    (rx_start),
		.stop     (rx_stop),
		.limit_ms (rx_limit),
		.running  (rx_running),
		.expire   (rx_expire)
	);

	// ==========================================================
	// decode of configuration fields
	always_comb begin
		func = edpn_pkg::edpn_func_t'(st_reg.ctrl[edpn_pkg::FUNC_HI:edpn_pkg::FUNC_LO]);
		case (st_reg.cfg[edpn_pkg::TXIV_HI:edpn_pkg::TXIV_LO])
			2'b00:   tx_limit = edpn_pkg::TX_IV_00_MS;
			2'b01:   tx_limit = edpn_pkg::TX_IV_01_MS;
			2'b10:   tx_limit = edpn_pkg::TX_IV_10_MS;
			2'b11:   tx_limit = edpn_pkg::TX_IV_11_MS;
			default: tx_limit = edpn_pkg::TX_IV_00_MS;
		endcase
		case (st_reg.cfg[edpn_pkg::RXIV_HI:edpn_pkg::RXIV_LO])
			2'b00:   rx_limit = edpn_pkg::RX_IV_00_MS;
			2'b01:   rx_limit = edpn_pkg::RX_IV_01_MS;
			2'b10:   rx_limit = edpn_pkg::RX_IV_10_MS;
			2'b11:   rx_limit = edpn_pkg::RX_IV_11_MS;
			default: rx_limit = edpn_pkg::RX_IV_00_MS;
		endcase
	end

	// pulses only with mode bit, real power-down, and peer rule
	assign tx_allowed = st_reg.cfg[edpn_pkg::TXEN_BIT]
		&& st_reg.mode[edpn_pkg::ENERGY_DETECT_POWER_DOWN_EN_BIT] && st_reg.sync_pd[2]
		&& (st_reg.cfg[edpn_pkg::INDEP_BIT] || st_reg.sync_peer[2]);
	// timer is started again as soon as it stops running, so pulses stay periodic
	assign tx_start   = tx_allowed && !tx_running;
	assign rx_edge    = st_reg.sync_rx[1] && !st_reg.sync_rx[2];
	assign rx_start   = rx_edge && !st_reg.pulse_seen;
	assign rx_stop    = !st_reg.sync_pd[2] || (rx_edge && st_reg.pulse_seen);

	// ==========================================================
	// next state
	always_comb begin
		st_next           = st_reg;
		st_next.mmd.mmd_wr = 1'b0;
		st_next.mmd.mmd_rd = 1'b0;
		st_next.tx_pulse  = tx_allowed && tx_expire;
		st_next.wake      = 1'b0;
		st_next.sync_pd   = {st_reg.sync_pd[1:0], phy_in_power_down};
		st_next.sync_peer = {st_reg.sync_peer[1:0], peer_port_power_down};
		st_next.sync_rx   = {st_reg.sync_rx[1:0], rx_link_pulse};

		// wake detection only in power-down with the mode enabled
		if (!st_reg.sync_pd[2] || !st_reg.mode[edpn_pkg::ENERGY_DETECT_POWER_DOWN_EN_BIT]) begin
			st_next.pulse_seen = 1'b0;
		end else if (rx_edge) begin
			if (st_reg.cfg[edpn_pkg::SINGLE_BIT] || st_reg.pulse_seen) begin
				st_next.wake       = 1'b1;
				st_next.pulse_seen = 1'b0;
			end else begin
				st_next.pulse_seen = 1'b1;
			end
		end else if (rx_expire) begin
			st_next.pulse_seen = 1'b0;
		end

		// soft reset leaves the preserved configuration alone
		if (phy_soft_reset) begin
			st_next.ctrl  = edpn_pkg::CTRL_RST;
			st_next.addat = edpn_pkg::ADDAT_RST;
			st_next.mode  = edpn_pkg::MODE_RST;
		end else if (req.wr) begin
			case (req.addr)
				edpn_pkg::IDX_MMD_CTRL:
					st_next.ctrl = req.wdata & edpn_pkg::CTRL_MASK;
				edpn_pkg::IDX_MMD_ADDAT: begin
					if (func == edpn_pkg::EDPN_FN_ADDR) begin
						st_next.addat    = req.wdata;
						st_next.mmd.addr = req.wdata;
					end else if (func == edpn_pkg::EDPN_FN_DATA) begin
						st_next.addat      = req.wdata;
						st_next.mmd.wdata  = req.wdata;
						st_next.mmd.mmd_wr = 1'b1;
					end
				end
				edpn_pkg::IDX_ENERGY_DETECT_POWER_DOWN_CFG:
					st_next.cfg = req.wdata & edpn_pkg::CFG_MASK;
				edpn_pkg::IDX_MODE_CTRL:
					st_next.mode = req.wdata & edpn_pkg::MODE_MASK;
				default: ;
			endcase
		end
		st_next.mmd.dev = st_next.ctrl[edpn_pkg::DEV_HI:edpn_pkg::DEV_LO];

		// reads answer in the next cycle; unmapped reads give zero
		st_next.rdata = 16'h0000;
		if (req.rd) begin
			case (req.addr)
				edpn_pkg::IDX_MMD_CTRL:  st_next.rdata = st_reg.ctrl;
				edpn_pkg::IDX_MMD_ADDAT: begin
					if (func == edpn_pkg::EDPN_FN_DATA) begin
						st_next.rdata      = mmd_rdata;
						st_next.mmd.mmd_rd = 1'b1;
					end else begin
						st_next.rdata = st_reg.addat;
					end
				end
				edpn_pkg::IDX_ENERGY_DETECT_POWER_DOWN_CFG:  st_next.rdata = st_reg.cfg;
				edpn_pkg::IDX_MODE_CTRL: st_next.rdata = st_reg.mode;
				default:                 st_next.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_reg       <= '0;
			st_reg.ctrl  <= edpn_pkg::CTRL_RST;
			st_reg.addat <= edpn_pkg::ADDAT_RST;
			st_reg.cfg   <= edpn_pkg::CFG_RST;
			st_reg.mode  <= edpn_pkg::MODE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata                          = st_reg.rdata;
	assign mmd                            = st_reg.mmd;
	assign energy_detect_powerdown_enable = st_reg.mode[edpn_pkg::ENERGY_DETECT_POWER_DOWN_EN_BIT];
	assign tx_link_pulse                  = st_reg.tx_pulse;
	assign wake                           = st_reg.wake;

	// ==========================================================
	// checks
	sequence s_pd_off;
		!st_reg.sync_pd[2];
	endsequence

	// software write to the window register, not masked by soft reset
	sequence s_addat_wr;
		req.wr && req.addr == edpn_pkg::IDX_MMD_ADDAT && !phy_soft_reset;
	endsequence

	sequence s_addat_rd;
		req.rd && req.addr == edpn_pkg::IDX_MMD_ADDAT;
	endsequence

	chk_tx_needs_pd: assert property (@(posedge mclk) disable iff (!rstn)
		tx_link_pulse |-> $past(st_reg.sync_pd[2]) && $past(st_reg.mode[edpn_pkg::ENERGY_DETECT_POWER_DOWN_EN_BIT]))
		else $error("link pulse outside power-down");

	chk_tx_enable_off: assert property (@(posedge mclk) disable iff (!rstn)
		!st_reg.cfg[edpn_pkg::TXEN_BIT] ##1 !st_reg.cfg[edpn_pkg::TXEN_BIT] |-> !tx_link_pulse)
		else $error("link pulse with enable clear");

	chk_tx_peer_wait: assert property (@(posedge mclk) disable iff (!rstn)
		tx_link_pulse |-> $past(st_reg.cfg[edpn_pkg::INDEP_BIT] || st_reg.sync_peer[2]))
		else $error("link pulse while peer port active");

	chk_single_wake: assert property (@(posedge mclk) disable iff (!rstn)
		rx_edge && st_reg.cfg[edpn_pkg::SINGLE_BIT] && st_reg.sync_pd[2]
		&& st_reg.mode[edpn_pkg::ENERGY_DETECT_POWER_DOWN_EN_BIT] |=> wake)
		else $error("single pulse did not wake");

	chk_double_wake: assert property (@(posedge mclk) disable iff (!rstn)
		wake |-> $past(st_reg.cfg[edpn_pkg::SINGLE_BIT] || st_reg.pulse_seen))
		else $error("wake without second pulse");

	chk_addr_latch: assert property (@(posedge mclk) disable iff (!rstn)
		req.wr && req.addr == edpn_pkg::IDX_MMD_ADDAT && func == edpn_pkg::EDPN_FN_ADDR
		&& !phy_soft_reset |=> mmd.addr == $past(req.wdata))
		else $error("mmd address not latched");

	chk_no_incr: assert property (@(posedge mclk) disable iff (!rstn)
		mmd.mmd_wr || mmd.mmd_rd |-> $stable(mmd.addr))
		else $error("mmd address moved on data access");

	chk_rsv_zero: assert property (@(posedge mclk) disable iff (!rstn)
		(st_reg.ctrl & ~edpn_pkg::CTRL_MASK) == 16'h0000
		&& (st_reg.cfg & ~edpn_pkg::CFG_MASK) == 16'h0000)
		else $error("reserved bits set");

	chk_soft_keep: assert property (@(posedge mclk) disable iff (!rstn)
		phy_soft_reset |=> $stable(st_reg.cfg))
		else $error("config lost on soft reset");

	chk_mode_write: assert property (@(posedge mclk) disable iff (!rstn)
		req.wr && req.addr == edpn_pkg::IDX_MODE_CTRL && !phy_soft_reset
		|=> energy_detect_powerdown_enable == $past(req.wdata[edpn_pkg::ENERGY_DETECT_POWER_DOWN_EN_BIT]))
		else $error("mode enable not written");

	chk_dev_sel: assert property (@(posedge mclk) disable iff (!rstn)
		req.wr && req.addr == edpn_pkg::IDX_MMD_CTRL && !phy_soft_reset
		|=> mmd.dev == $past(req.wdata[edpn_pkg::DEV_HI:edpn_pkg::DEV_LO]))
		else $error("device select mismatch");

	chk_pd_clears: assert property (@(posedge mclk) disable iff (!rstn)
		s_pd_off |=> !st_reg.pulse_seen)
		else $error("pulse memory kept out of power-down");

	chk_data_write: assert property (@(posedge mclk) disable iff (!rstn)
		s_addat_wr ##0 func == edpn_pkg::EDPN_FN_DATA
		|=> mmd.mmd_wr && mmd.wdata == $past(req.wdata))
		else $error("mmd data write not issued");

	chk_data_read: assert property (@(posedge mclk) disable iff (!rstn)
		s_addat_rd ##0 func == edpn_pkg::EDPN_FN_DATA
		|=> mmd.mmd_rd && rdata == $past(mmd_rdata))
		else $error("mmd data read not returned");

	chk_rsv_func: assert property (@(posedge mclk) disable iff (!rstn)
		s_addat_wr ##0 func[1]
		|=> !mmd.mmd_wr && $stable(mmd.addr))
		else $error("reserved function reached mmd space");

	chk_wake_in_pd: assert property (@(posedge mclk) disable iff (!rstn)
		wake |-> $past(st_reg.sync_pd[2] && st_reg.mode[edpn_pkg::ENERGY_DETECT_POWER_DOWN_EN_BIT]))
		else $error("wake outside power-down");

	chk_soft_clear: assert property (@(posedge mclk) disable iff (!rstn)
		phy_soft_reset |=> st_reg.ctrl == edpn_pkg::CTRL_RST
		&& st_reg.mode == edpn_pkg::MODE_RST)
		else $error("soft reset left control set");
endmodule

// >>> core/edpn_pkg.sv
// package: register map, field layout, timing counts for the mmd/energy_detect_power_down register block
package edpn_pkg;

	// ==========================================================
	// register indexes and bus widths
	localparam int          ADDR_W          = 5;
	localparam int          DATA_W          = 16;
	localparam logic [4:0]  IDX_MMD_CTRL    = 5'h0D;
	localparam logic [4:0]  IDX_MMD_ADDAT   = 5'h0E;
	localparam logic [4:0]  IDX_ENERGY_DETECT_POWER_DOWN_CFG    = 5'h10;
	localparam logic [4:0]  IDX_MODE_CTRL   = 5'h11;

	// ==========================================================
	// field positions
	localparam int          FUNC_HI         = 15;
	localparam int          FUNC_LO         = 14;
	localparam int          DEV_HI          = 4;
	localparam int          DEV_LO          = 0;
	localparam int          TXEN_BIT        = 15;
	localparam int          TXIV_HI         = 14;
	localparam int          TXIV_LO         = 13;
	localparam int          SINGLE_BIT      = 12;
	localparam int          RXIV_HI         = 11;
	localparam int          RXIV_LO         = 10;
	localparam int          INDEP_BIT       = 3;
	localparam int          ENERGY_DETECT_POWER_DOWN_EN_BIT     = 13;

	// writable masks; everything else reads zero
	localparam logic [15:0] CTRL_MASK       = 16'hC01F;
	localparam logic [15:0] CFG_MASK        = 16'hFC08;
	localparam logic [15:0] MODE_MASK       = 16'h2000;

	// ==========================================================
	// reset values
	localparam logic [15:0] CTRL_RST        = 16'h0000;
	localparam logic [15:0] ADDAT_RST       = 16'h0000;
	localparam logic [15:0] CFG_RST         = 16'h0000;
	localparam logic [15:0] MODE_RST        = 16'h0000;

	// ==========================================================
	// function and device codes
	typedef enum logic [1:0] {
		EDPN_FN_ADDR  = 2'b00,
		EDPN_FN_DATA  = 2'b01,
		EDPN_FN_RSV2  = 2'b10,
		EDPN_FN_RSV3  = 2'b11
	} edpn_func_t;
	localparam logic [4:0]  DEV_PCS         = 5'h03;
	localparam logic [4:0]  DEV_AN          = 5'h07;

	// ==========================================================
	// timing: one ms tick from the 50 MHz clock
	localparam int          CLK_KHZ         = 50000;
	localparam int          MS_CYCLES       = CLK_KHZ;
	localparam int          MS_W            = 16;
	localparam int          IV_W            = 11;
	localparam logic [10:0] TX_IV_00_MS     = 11'h3E8;
	localparam logic [10:0] TX_IV_01_MS     = 11'h300;
	localparam logic [10:0] TX_IV_10_MS     = 11'h200;
	localparam logic [10:0] TX_IV_11_MS     = 11'h100;
	localparam logic [10:0] RX_IV_00_MS     = 11'h040;
	localparam logic [10:0] RX_IV_01_MS     = 11'h100;
	localparam logic [10:0] RX_IV_10_MS     = 11'h200;
	localparam logic [10:0] RX_IV_11_MS     = 11'h3E8;

	// ==========================================================
	// bus carriers
	typedef struct packed {
		logic [4:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} edpn_req_t;

	typedef struct packed {
		logic        mmd_wr;
		logic        mmd_rd;
		logic [4:0]  dev;
		logic [15:0] addr;
		logic [15:0] wdata;
	} edpn_mmd_t;

endpackage

// >>> core/edpn_ms_tick.sv
// one-millisecond enable pulse divider
`timescale 1ns/10ps
module edpn_ms_tick (
	input  wire logic mclk,
	input  wire logic rstn,
	output logic      tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} edpn_tick_st_t;

	edpn_tick_st_t st_reg;
	edpn_tick_st_t st_next;

	always_comb begin
		st_next      = st_reg;
		st_next.tick = 1'b0;
		if (st_reg.cnt == 16'(edpn_pkg::MS_CYCLES - 1)) begin
			st_next.cnt  = 16'h0000;
			st_next.tick = 1'b1;
		end else begin
			st_next.cnt = st_reg.cnt + 16'h0001;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick = st_reg.tick;
endmodule

// >>> core/edpn_ms_timer.sv
// millisecond interval timer: restart, expiry pulse, running flag
`timescale 1ns/10ps
module edpn_ms_timer (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        ms_tick,
	input  wire logic        start,
	input  wire logic        stop,
	input  wire logic [10:0] limit_ms,
	output logic             running,
	output logic             expire
);
	typedef struct packed {
		logic [10:0] cnt;
		logic        run;
		logic        exp;
	} edpn_tmr_st_t;

	edpn_tmr_st_t st_reg;
	edpn_tmr_st_t st_next;

	always_comb begin
		st_next     = st_reg;
		st_next.exp = 1'b0;
		if (stop) begin
			st_next.run = 1'b0;
			st_next.cnt = 11'h000;
		end else if (start) begin
			st_next.run = 1'b1;
			st_next.cnt = 11'h000;
		end else if (st_reg.run && ms_tick) begin
			if (st_reg.cnt + 11'h001 >= limit_ms) begin
				st_next.run = 1'b0;
				st_next.exp = 1'b1;
				st_next.cnt = 11'h000;
			end else begin
				st_next.cnt = st_reg.cnt + 11'h001;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign running = st_reg.run;
	assign expire  = st_reg.exp;
endmodule

// >>> test/edpn_link_partner.sv
// remote link partner model: sends wake pulses, counts pulses it receives
`timescale 1ns/10ps
module edpn_link_partner (
	input  wire logic mclk,
	input  wire logic send,
	input  wire logic tx_link_pulse,
	output logic      rx_link_pulse,
	output int        tx_seen
);
	// ==========================================================
	// pulse shaping
	// stretched over several cycles so the far side's sync flops see it
	int   hold_cnt = 0;
	int   seen_cnt = 0;
	logic line_q   = 1'b0;

	always @(posedge mclk) begin
		if (send) begin
			hold_cnt <= 4;
		end else if (hold_cnt > 0) begin
			hold_cnt <= hold_cnt - 1;
		end
		// line returns low between pulses, its idle level
		line_q <= send || (hold_cnt > 1);
		if (tx_link_pulse === 1'b1) begin
			seen_cnt <= seen_cnt + 1;
		end
	end

	assign rx_link_pulse = line_q;
	assign tx_seen       = seen_cnt;
endmodule

// >>> test/edpn_regs_tb.sv
// self-checking bench for the mmd window and energy-detect pulse registers
`timescale 1ns/10ps
module edpn_regs_tb;
	logic                mclk, rstn, phy_soft_reset, send;
	logic                phy_in_power_down, peer_port_power_down, rx_link_pulse;
	logic                energy_detect_powerdown_enable, tx_link_pulse, wake, got;
	logic [15:0]         rdata, mmd_rdata, cfg;
	edpn_pkg::edpn_req_t req;
	edpn_pkg::edpn_mmd_t mmd;
	int                  n_fail, n_tests, tx_seen;

	edpn_regs uut (.mclk(mclk), .rstn(rstn), .phy_soft_reset(phy_soft_reset), .req(req),
		.rdata(rdata), .phy_in_power_down(phy_in_power_down),
		.peer_port_power_down(peer_port_power_down), .rx_link_pulse(rx_link_pulse),
		.mmd_rdata(mmd_rdata), .mmd(mmd),
		.energy_detect_powerdown_enable(energy_detect_powerdown_enable),
		.tx_link_pulse(tx_link_pulse), .wake(wake));

	edpn_link_partner partner (.mclk(mclk), .send(send), .tx_link_pulse(tx_link_pulse),
		.rx_link_pulse(rx_link_pulse), .tx_seen(tx_seen));

	always #10 mclk = ~mclk;

	// ==========================================================
	// shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		if (n_fail == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// the sample point lands inside the answer cycle, after its edge settles
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk) req <= '0;
		#1;
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
		@(posedge mclk) req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge mclk) req <= '0;
		#1;
		check(rdata, exp);
	endtask

	task automatic pulse();
		@(posedge mclk) send <= 1'b1;
		@(posedge mclk) send <= 1'b0;
	endtask

	task automatic wait_wake(input int bound, output logic seen);
		seen = 1'b0;
		for (int i = 0; i < bound && !seen; i++) begin
			@(posedge mclk) #1;
			seen = (wake === 1'b1);
		end
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset_values();
		rd_chk(edpn_pkg::IDX_MMD_CTRL, 16'h0000);
		rd_chk(edpn_pkg::IDX_MMD_ADDAT, 16'h0000);
		rd_chk(edpn_pkg::IDX_ENERGY_DETECT_POWER_DOWN_CFG, 16'h0000);
		rd_chk(edpn_pkg::IDX_MODE_CTRL, 16'h0000);
		wr(5'h05, 16'hFFFF);
		rd_chk(5'h05, 16'h0000);
	endtask

	task automatic t_ctrl_fields();
		logic [4:0] devs [3] = '{edpn_pkg::DEV_PCS, edpn_pkg::DEV_AN, 5'h1F};
		wr(edpn_pkg::IDX_MMD_CTRL, 16'hFFFF);
		rd_chk(edpn_pkg::IDX_MMD_CTRL, 16'hC01F);
		foreach (devs[i]) begin
			wr(edpn_pkg::IDX_MMD_CTRL, {11'h000, devs[i]});
			check({11'h000, mmd.dev}, {11'h000, devs[i]});
		end
	endtask

	task automatic t_address_mode();
		wr(edpn_pkg::IDX_MMD_CTRL, 16'h0007);
		wr(edpn_pkg::IDX_MMD_ADDAT, 16'h0020);
		check(mmd.addr, 16'h0020);
		check({15'h0000, mmd.mmd_wr}, 16'h0000);
		rd_chk(edpn_pkg::IDX_MMD_ADDAT, 16'h0020);
	endtask

	task automatic t_data_mode();
		wr(edpn_pkg::IDX_MMD_CTRL, 16'h4007);
		wr(edpn_pkg::IDX_MMD_ADDAT, 16'h1234);
		check({15'h0000, mmd.mmd_wr}, 16'h0001);
		check(mmd.wdata, 16'h1234);
		wr(edpn_pkg::IDX_MMD_ADDAT, 16'h5678);
		check(mmd.addr, 16'h0020);
		mmd_rdata <= 16'hBEEF;
		rd_chk(edpn_pkg::IDX_MMD_ADDAT, 16'hBEEF);
		check({15'h0000, mmd.mmd_rd}, 16'h0001);
		check(mmd.addr, 16'h0020);
	endtask

	task automatic t_reserved_func();
		for (int f = 2; f < 4; f++) begin
			wr(edpn_pkg::IDX_MMD_CTRL, {f[1:0], 14'h0007});
			rd_chk(edpn_pkg::IDX_MMD_CTRL, {f[1:0], 14'h0007});
			wr(edpn_pkg::IDX_MMD_ADDAT, 16'h0099);
			check({15'h0000, mmd.mmd_wr}, 16'h0000);
			check(mmd.addr, 16'h0020);
		end
	endtask

	task automatic t_config();
		logic [10:0] tx_ms [4] = '{edpn_pkg::TX_IV_00_MS, edpn_pkg::TX_IV_01_MS,
			edpn_pkg::TX_IV_10_MS, edpn_pkg::TX_IV_11_MS};
		logic [10:0] rx_ms [4] = '{edpn_pkg::RX_IV_00_MS, edpn_pkg::RX_IV_01_MS,
			edpn_pkg::RX_IV_10_MS, edpn_pkg::RX_IV_11_MS};
		wr(edpn_pkg::IDX_ENERGY_DETECT_POWER_DOWN_CFG, 16'hFFFF);
		rd_chk(edpn_pkg::IDX_ENERGY_DETECT_POWER_DOWN_CFG, 16'hFC08);
		// tx enable always written together with independent mode
		for (int i = 0; i < 4; i++) begin
			cfg = {1'b1, i[1:0], 1'b0, i[1:0], 6'h00, 1'b1, 3'h0};
			wr(edpn_pkg::IDX_ENERGY_DETECT_POWER_DOWN_CFG, cfg);
			rd_chk(edpn_pkg::IDX_ENERGY_DETECT_POWER_DOWN_CFG, cfg);
			check({5'h00, uut.tx_limit}, {5'h00, tx_ms[i]});
			check({5'h00, uut.rx_limit}, {5'h00, rx_ms[i]});
		end
		wr(edpn_pkg::IDX_MODE_CTRL, 16'hFFFF);
		rd_chk(edpn_pkg::IDX_MODE_CTRL, 16'h2000);
		check({15'h0000, energy_detect_powerdown_enable}, 16'h0001);
	endtask

	task automatic t_soft_reset();
		@(posedge mclk) phy_soft_reset <= 1'b1;
		@(posedge mclk) phy_soft_reset <= 1'b0;
		rd_chk(edpn_pkg::IDX_ENERGY_DETECT_POWER_DOWN_CFG, 16'hEC08);
		rd_chk(edpn_pkg::IDX_MODE_CTRL, 16'h0000);
		rd_chk(edpn_pkg::IDX_MMD_CTRL, 16'h0000);
	endtask

	task automatic t_wake();
		wr(edpn_pkg::IDX_MODE_CTRL, 16'h2000);
		// single wake suits low-energy partners
		wr(edpn_pkg::IDX_ENERGY_DETECT_POWER_DOWN_CFG, 16'h9008);
		phy_in_power_down <= 1'b1;
		peer_port_power_down <= 1'b1;
		repeat (6) @(posedge mclk);
		pulse();
		wait_wake(20, got);
		check({15'h0000, got}, 16'h0001);
		wr(edpn_pkg::IDX_ENERGY_DETECT_POWER_DOWN_CFG, 16'h8008);
		pulse();
		wait_wake(30, got);
		check({15'h0000, got}, 16'h0000);
		pulse();
		wait_wake(20, got);
		check({15'h0000, got}, 16'h0001);
		// far too early for the first transmit interval to have run out
		check(tx_seen[15:0], 16'h0000);
	endtask

	// transmit gating; intervals are far too long to wait out here
	task automatic t_tx_gate();
		peer_port_power_down <= 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		check({15'h0000, uut.tx_allowed}, 16'h0001);
		wr(edpn_pkg::IDX_ENERGY_DETECT_POWER_DOWN_CFG, 16'h0008);
		check({15'h0000, uut.tx_allowed}, 16'h0000);
		wr(edpn_pkg::IDX_ENERGY_DETECT_POWER_DOWN_CFG, 16'h8008);
		wr(edpn_pkg::IDX_MODE_CTRL, 16'h0000);
		check({15'h0000, uut.tx_allowed}, 16'h0000);
		wr(edpn_pkg::IDX_MODE_CTRL, 16'h2000);
		phy_in_power_down <= 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		check({15'h0000, uut.tx_allowed}, 16'h0000);
		check(tx_seen[15:0], 16'h0000);
	endtask

	task automatic t_hard_reset();
		@(posedge mclk) rstn <= 1'b0;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		rd_chk(edpn_pkg::IDX_ENERGY_DETECT_POWER_DOWN_CFG, 16'h0000);
		check({15'h0000, energy_detect_powerdown_enable}, 16'h0000);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		mclk = 1'b0;
		rstn = 1'b0;
		phy_soft_reset = 1'b0;
		send = 1'b0;
		phy_in_power_down = 1'b0;
		peer_port_power_down = 1'b0;
		mmd_rdata = 16'h0000;
		req = '0;
		n_fail = 0;
		n_tests = 0;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		t_reset_values();
		t_ctrl_fields();
		t_address_mode();
		t_data_mode();
		t_reserved_func();
		t_config();
		t_soft_reset();
		t_wake();
		t_tx_gate();
		t_hard_reset();
		complete_run();
	end
endmodule
